//--- rtl/ucrw_clock_wakeup.sv
// APB register block for USB clock sequencing, transceiver control, soft reset and remote wakeup
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Oscillator buffer enable passes clock to PLL
// - PLL enabled multiplies input by selected factor
// - PLL disabled passes clock through; needs 48MHz
// - Clock select codes 00/10/01/11 mean 48/24/12/6MHz
// - Internal clock enable gates the core clock
// - Resume detection stays alive while suspended
// - Transceiver-on field drives pin and engine enable
// - Operation enable low holds module soft reset
// - Wakeup write acts only while suspended
// - Wakeup drives K for 10ms then self-clears
// - Bus idle until 2ms after suspend, bit reads one
// - Interval counting pauses while clock is absent
// - Wakeup reads one while pending; zero writes ignored
module ucrw_clock_wakeup #(
  parameter int unsigned IDLE_CYCLES = ucrw_pkg::IDLE_CYCLES,
  parameter int unsigned K_CYCLES = ucrw_pkg::K_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ucrw_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device state from the USB state machine
  input wire logic [2:0] device_state_field,
  // Clock control
  output logic osc_buffer_enable,
  output logic pll_enable,
  output logic [1:0] pll_clock_select,
  output logic [3:0] pll_mult_factor,
  output logic core_clock_enable,
  // Transceiver and engine
  output logic transceiver_power,
  output logic transceiver_on_pin_out,
  output logic transceiver_on_pin_oe,
  output logic serial_interface_engine_enable,
  output logic resume_detect_enable,
  // Module soft reset, active low
  output logic module_soft_reset_n,
  // Remote wakeup
  output logic wakeup_request,
  output logic wakeup_k_drive
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic [3:0] mult_of(input logic pll_on, input logic [1:0] sel);
    logic [3:0] f;
    f = 4'h1;
    if (pll_on) begin
      case (sel)
        ucrw_pkg::CLK_SEL_24M: f = 4'h2;
        ucrw_pkg::CLK_SEL_12M: f = 4'h4;
        ucrw_pkg::CLK_SEL_6M: f = 4'h8;
        default: f = 4'h1;
      endcase
    end
    return f;
  endfunction : mult_of

  ////////////////////////////////////////////////////////////////////////////
  // APB access

  logic [15:0] oper_ctrl_reg;
  logic access;
  logic wr_fire;
  logic hit_oper;
  logic hit_wake;
  logic suspended;
  logic clock_ok;
  logic idle_elapsed;
  logic k_done;
  ucrw_pkg::ucrw_wake_state_t wake_state_reg;
  ucrw_pkg::ucrw_wake_state_t wake_state_next;

  assign access = psel && penable;
  assign hit_oper = (paddr == {ucrw_pkg::OPER_CTRL_IDX[5:0], 2'h0});
  assign hit_wake = (paddr == {ucrw_pkg::WAKE_CTRL_IDX[5:0], 2'h0});
  assign wr_fire = access && pready && pwrite;
  assign suspended = device_state_field[ucrw_pkg::DEV_STATE_SUSPEND_BIT];
  // Interval clock exists only with both the buffer and the core gate open
  assign clock_ok = osc_buffer_enable && core_clock_enable;

  // One wait state: pready rises in the second access cycle, then drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (access && !pready) begin
      pready <= 1'b1;
      pslverr <= !(hit_oper || hit_wake);
      if (pwrite || !(hit_oper || hit_wake)) begin
        prdata <= 32'h0;
      end else if (hit_oper) begin
        prdata <= {16'h0, oper_ctrl_reg & ucrw_pkg::OPER_CTRL_MASK};
      end else begin
        prdata <= {31'h0, wakeup_request};
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operation control register

  // Only hardware reset clears it; soft reset leaves it alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oper_ctrl_reg <= ucrw_pkg::OPER_CTRL_RESET;
    end else if (wr_fire && hit_oper) begin
      oper_ctrl_reg <= pwdata[15:0] & ucrw_pkg::OPER_CTRL_MASK;
    end
  end

  assign osc_buffer_enable = oper_ctrl_reg[ucrw_pkg::OSC_BUF_EN_BIT];
  assign pll_enable = oper_ctrl_reg[ucrw_pkg::PLL_EN_BIT];
  assign pll_clock_select = oper_ctrl_reg[ucrw_pkg::CLK_SEL_HI:ucrw_pkg::CLK_SEL_LO];
  assign core_clock_enable = oper_ctrl_reg[ucrw_pkg::CORE_CLK_EN_BIT];
  assign transceiver_power = oper_ctrl_reg[ucrw_pkg::XCVR_PWR_BIT];
  assign module_soft_reset_n = oper_ctrl_reg[ucrw_pkg::MOD_EN_BIT];
  assign wakeup_k_drive = wake_state_reg[2];

  ////////////////////////////////////////////////////////////////////////////
  // Derived flops: multiplier, pin drive, engine, resume detection

  // Factor 1 means bypass; the pass-through input must then be 48 MHz
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_mult_factor <= 4'h1;
    end else begin
      pll_mult_factor <= mult_of(oper_ctrl_reg[ucrw_pkg::PLL_EN_BIT],
                                 oper_ctrl_reg[ucrw_pkg::CLK_SEL_HI:ucrw_pkg::CLK_SEL_LO]);
    end
  end

  // The reserved code is left undriven, the safest reading of it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transceiver_on_pin_out <= 1'b0;
      transceiver_on_pin_oe <= 1'b0;
      serial_interface_engine_enable <= 1'b0;
      resume_detect_enable <= 1'b0;
    end else begin
      transceiver_on_pin_out <= (oper_ctrl_reg[ucrw_pkg::TRANSCEIVER_ON_PIN_HI:ucrw_pkg::TRANSCEIVER_ON_PIN_LO] == ucrw_pkg::TRANSCEIVER_ON_PIN_HIGH);
      transceiver_on_pin_oe <= (oper_ctrl_reg[ucrw_pkg::TRANSCEIVER_ON_PIN_HI:ucrw_pkg::TRANSCEIVER_ON_PIN_LO] == ucrw_pkg::TRANSCEIVER_ON_PIN_LOW) ||
                               (oper_ctrl_reg[ucrw_pkg::TRANSCEIVER_ON_PIN_HI:ucrw_pkg::TRANSCEIVER_ON_PIN_LO] == ucrw_pkg::TRANSCEIVER_ON_PIN_HIGH);
      serial_interface_engine_enable <= oper_ctrl_reg[ucrw_pkg::TRANSCEIVER_ON_PIN_LO];
      // Receiver stays live for resume even with transceiver power off
      resume_detect_enable <= oper_ctrl_reg[ucrw_pkg::XCVR_PWR_BIT] || suspended;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Remote wakeup sequencing

  ucrw_interval_timer #(
    .LIMIT(IDLE_CYCLES)
  ) u_idle_timer (
    .pclk(pclk),
    .presetn(presetn),
    .clear(!suspended),
    .run(suspended && clock_ok),
    .done(idle_elapsed)
  );

  ucrw_interval_timer #(
    .LIMIT(K_CYCLES)
  ) u_k_timer (
    .pclk(pclk),
    .presetn(presetn),
    .clear(wake_state_reg != ucrw_pkg::WAKE_KDRIVE),
    .run(clock_ok),
    .done(k_done)
  );

  always_comb begin
    wake_state_next = wake_state_reg;
    case (wake_state_reg)
      ucrw_pkg::WAKE_IDLE: begin
        // A one written outside suspend, or any zero, is dropped
        if (wr_fire && hit_wake && pwdata[ucrw_pkg::WAKE_BIT] && suspended) begin
          wake_state_next = ucrw_pkg::WAKE_WAIT;
        end
      end
      ucrw_pkg::WAKE_WAIT: begin
        if (!suspended) begin
          wake_state_next = ucrw_pkg::WAKE_IDLE;
        end else if (idle_elapsed) begin
          wake_state_next = ucrw_pkg::WAKE_KDRIVE;
        end
      end
      ucrw_pkg::WAKE_KDRIVE: begin
        // The host answers K by leaving suspend, so suspend is not watched here
        if (k_done) begin
          wake_state_next = ucrw_pkg::WAKE_IDLE;
        end
      end
      default: wake_state_next = ucrw_pkg::WAKE_IDLE;
    endcase
  end

  // The readable bit has its own flop so the output needs no decode after the state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_state_reg <= ucrw_pkg::WAKE_IDLE;
      wakeup_request <= 1'b0;
    end else if (!module_soft_reset_n) begin
      wake_state_reg <= ucrw_pkg::WAKE_IDLE;
      wakeup_request <= 1'b0;
    end else begin
      wake_state_reg <= wake_state_next;
      wakeup_request <= (wake_state_next != ucrw_pkg::WAKE_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wake_write_one;
    wr_fire && hit_wake && pwdata[ucrw_pkg::WAKE_BIT];
  endsequence

  sequence s_k_start;
    $rose(wakeup_k_drive);
  endsequence

  a_wake_ignored_awake: assert property (
    s_wake_write_one ##0 (!suspended && !wakeup_request) |=> !wakeup_request)
    else $error("wakeup accepted while not suspended");

  a_wake_taken_suspend: assert property (
    s_wake_write_one ##0 (suspended && !wakeup_request && module_soft_reset_n) |=> wakeup_request && !wakeup_k_drive)
    else $error("wakeup write in suspend not taken or K started at once");

  a_k_after_idle: assert property (
    s_k_start |-> $past(idle_elapsed) && $past(wakeup_request))
    else $error("K state started before idle interval");

  a_k_holds_min: assert property (
    s_k_start ##0 module_soft_reset_n |-> (wakeup_k_drive || !module_soft_reset_n) [*8])
    else $error("K state ended too early");

  a_k_pause_clock: assert property (
    wakeup_k_drive && !clock_ok && module_soft_reset_n |=> wakeup_k_drive)
    else $error("K interval advanced without clock");

  a_k_autoclear: assert property (
    $fell(wakeup_k_drive) |-> !wakeup_request)
    else $error("wakeup bit not cleared after K");

  a_osc_follow_write: assert property (
    wr_fire && hit_oper |=> osc_buffer_enable == $past(pwdata[ucrw_pkg::OSC_BUF_EN_BIT])
      && core_clock_enable == $past(pwdata[ucrw_pkg::CORE_CLK_EN_BIT]))
    else $error("clock enables did not follow write");

  a_pll_bypass_unity: assert property (
    !pll_enable && $stable(pll_enable) |=> pll_mult_factor == 4'h1)
    else $error("multiplier not unity with PLL off");

  a_pll_6m_factor: assert property (
    pll_enable && pll_clock_select == ucrw_pkg::CLK_SEL_6M |=> pll_mult_factor == 4'h8)
    else $error("6 MHz select did not give factor 8");

  a_transceiver_on_pin_hiz_stop: assert property (
    $past(oper_ctrl_reg[ucrw_pkg::TRANSCEIVER_ON_PIN_HI:ucrw_pkg::TRANSCEIVER_ON_PIN_LO]) == ucrw_pkg::TRANSCEIVER_ON_PIN_HIZ
      |-> !transceiver_on_pin_oe && !serial_interface_engine_enable)
    else $error("pin driven or engine on with code 00");

  a_resume_in_suspend: assert property (
    suspended |=> resume_detect_enable)
    else $error("resume detection off during suspend");

  a_soft_reset_wake: assert property (
    !module_soft_reset_n |=> !wakeup_request)
    else $error("wakeup survived soft reset");

  a_oper_kept_soft: assert property (
    !module_soft_reset_n && !(wr_fire && hit_oper) |=> $stable(oper_ctrl_reg))
    else $error("operation register changed under soft reset");

endmodule : ucrw_clock_wakeup

`default_nettype wire

//--- rtl/ucrw_interval_timer.sv
// Pausable interval counter that flags when a set number of run cycles has passed
`timescale 1ns/10ps
`default_nettype none

module ucrw_interval_timer #(
  parameter int unsigned LIMIT = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic clear,
  input wire logic run,
  // Status
  output logic done
);

  logic [31:0] count_reg;

  // Counting holds while run is low, so a stopped clock source pauses the interval
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 32'h0;
      done <= 1'b0;
    end else if (clear) begin
      count_reg <= 32'h0;
      done <= 1'b0;
    end else if (run && !done) begin
      count_reg <= count_reg + 32'h1;
      done <= (count_reg == LIMIT - 1);
    end
  end

endmodule : ucrw_interval_timer

`default_nettype wire

//--- rtl/ucrw_pkg.sv
// Shared constants for the USB clock-enable and remote-wakeup control block
package ucrw_pkg;

  // Register indices; the byte address on APB is four times the index
  localparam logic [7:0] OPER_CTRL_IDX = 8'h00;
  localparam logic [7:0] WAKE_CTRL_IDX = 8'h02;
  localparam int unsigned ADDR_W = 8;

  // Field positions of usb_operation_control
  localparam int unsigned OSC_BUF_EN_BIT = 15;
  localparam int unsigned PLL_EN_BIT = 14;
  localparam int unsigned CLK_SEL_HI = 13;
  localparam int unsigned CLK_SEL_LO = 12;
  localparam int unsigned CORE_CLK_EN_BIT = 11;
  localparam int unsigned XCVR_PWR_BIT = 10;
  localparam int unsigned TRANSCEIVER_ON_PIN_HI = 9;
  localparam int unsigned TRANSCEIVER_ON_PIN_LO = 8;
  localparam int unsigned MOD_EN_BIT = 0;
  localparam logic [15:0] OPER_CTRL_MASK = 16'hff01;
  localparam logic [15:0] OPER_CTRL_RESET = 16'h0000;

  // Field position of remote_wakeup_control
  localparam int unsigned WAKE_BIT = 0;

  // Clock-select codes: input frequency for a 48 MHz core clock
  localparam logic [1:0] CLK_SEL_48M = 2'h0;
  localparam logic [1:0] CLK_SEL_24M = 2'h2;
  localparam logic [1:0] CLK_SEL_12M = 2'h1;
  localparam logic [1:0] CLK_SEL_6M = 2'h3;

  // Transceiver-on control codes
  localparam logic [1:0] TRANSCEIVER_ON_PIN_HIZ = 2'h0;
  localparam logic [1:0] TRANSCEIVER_ON_PIN_LOW = 2'h1;
  localparam logic [1:0] TRANSCEIVER_ON_PIN_RSVD = 2'h2;
  localparam logic [1:0] TRANSCEIVER_ON_PIN_HIGH = 2'h3;

  // Suspended device states are 1xx
  localparam int unsigned DEV_STATE_SUSPEND_BIT = 2;

  // Timing
  localparam int unsigned CLK_KHZ = 40000;
  localparam int unsigned IDLE_TIME_US = 2000;
  localparam int unsigned K_TIME_US = 10000;
  localparam int unsigned IDLE_CYCLES = (IDLE_TIME_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned K_CYCLES = (K_TIME_US * CLK_KHZ + 999) / 1000;

  typedef enum logic [2:0] {
    WAKE_IDLE = 3'h1,
    WAKE_WAIT = 3'h2,
    WAKE_KDRIVE = 3'h4
  } ucrw_wake_state_t;

endpackage : ucrw_pkg

//--- testbench/tb.sv
// Self-checking bench for the clock-enable and remote-wakeup register block
`timescale 1ns/10ps
`default_nettype none

module tb;
  localparam int unsigned IDLE = 20;
  localparam int unsigned KC = 30;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sus = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, k_len, r, k0, kp;
  logic pready, pslverr, e, osc, pll, core, xpwr, tpin, toe, serial_interface_engine, rde, srn, wreq, kdrv;
  logic [1:0] sel;
  logic [3:0] mult;
  logic [2:0] dstate;
  logic [15:0] v;
  int err_count = 0, n_checks = 0, cyc = 0, c;

  ucrw_clock_wakeup #(.IDLE_CYCLES(IDLE), .K_CYCLES(KC)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .device_state_field(dstate), .osc_buffer_enable(osc),
    .pll_enable(pll), .pll_clock_select(sel), .pll_mult_factor(mult), .core_clock_enable(core),
    .transceiver_power(xpwr), .transceiver_on_pin_out(tpin), .transceiver_on_pin_oe(toe),
    .serial_interface_engine_enable(serial_interface_engine), .resume_detect_enable(rde), .module_soft_reset_n(srn),
    .wakeup_request(wreq), .wakeup_k_drive(kdrv));
  ucrw_usb_host_model host (.pclk(pclk), .presetn(presetn), .suspend_cmd(sus), .wakeup_k_drive(kdrv),
    .device_state_field(dstate), .k_len(k_len));

  initial begin
    forever #12.5 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so a following call never re-drives psel in this time step
    @(posedge pclk);
  endtask : apb

  function automatic logic [3:0] exp_mult(input logic [15:0] x);
    if (!x[14]) return 4'h1;
    case (x[13:12])
      2'h0: return 4'h1;
      2'h2: return 4'h2;
      2'h1: return 4'h4;
      default: return 4'h8;
    endcase
  endfunction : exp_mult

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(75));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("mult_rst", 32'h1, mult);
    apb(1'b0, 8'h00, 32'h0);
    chk("oper_rst", 32'h0, r);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      v = 16'($urandom) & 16'hccff | {2'h0, 2'(i >> 2), 2'h0, 2'(i), 8'h0};
      apb(1'b1, 8'h00, {16'hffff, v});
      apb(1'b0, 8'h00, 32'h0);
      chk("oper_rd", {16'h0, v & 16'hff01}, r);
      repeat (2) @(posedge pclk);
      chk("osc", v[15], osc);
      chk("pll", {v[14], v[13:12]}, {pll, sel});
      chk("mult", exp_mult(v), mult);
      chk("core", v[11], core);
      chk("xpwr", v[10], xpwr);
      chk("transceiver_on_pin", {v[9:8] == 2'h3, v[8], v[8]}, {tpin, toe, serial_interface_engine});
      chk("srn", v[0], srn);
    end
    $display("test fields done");
    apb(1'b0, 8'h04, 32'h0);
    chk("unmap_rd", 32'h1, {r[30:0], e});
    apb(1'b1, 8'h0c, 32'h1);
    chk("unmap_wr", 32'h1, e);
    $display("test unmapped done");
    apb(1'b1, 8'h00, 32'h8001);
    apb(1'b1, 8'h00, 32'hd001);
    apb(1'b1, 8'h00, 32'hd901);
    apb(1'b1, 8'h08, 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    chk("wake_nosus", 32'h0, r);
    sus <= 1'b1;
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk("wake_zero", 32'h0, r);
    apb(1'b1, 8'h08, 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    chk("wake_wait", 32'h1, {r[31:1], r[0] & ~kdrv});
    c = 16;
    while (kdrv !== 1'b1 && c < 200) begin
      @(posedge pclk);
      c++;
    end
    chk("idle_len", 32'h1, c >= IDLE && c <= IDLE + 6);
    k0 = k_len;
    apb(1'b1, 8'h00, 32'hd101);
    kp = k_len;
    repeat (20) @(posedge pclk);
    chk("k_paused", 32'h1, {kdrv, wreq} == 2'h3);
    apb(1'b1, 8'h00, 32'hd901);
    // K cycles seen while the core clock was gated are not part of the counted interval
    kp = k_len - kp;
    c = 0;
    while (kdrv !== 1'b0 && c < 300) begin
      @(posedge pclk);
      c++;
    end
    @(posedge pclk);
    chk("k_len", 32'h1, k_len - k0 - kp >= KC && k_len - k0 - kp <= KC + 4);
    chk("self_clr", 32'h0, wreq);
    $display("test wakeup done");
    apb(1'b1, 8'h08, 32'h1);
    apb(1'b1, 8'h00, 32'hd900);
    @(posedge pclk);
    chk("abort", 32'h0, {wreq, kdrv, srn});
    apb(1'b0, 8'h00, 32'h0);
    chk("oper_keep", 32'hd900, r);
    chk("resume_on", 32'h1, rde);
    sus <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("resume_off", 32'h0, rde);
    $display("test soft reset done");
    complete_run();
  end
endmodule : tb
`default_nettype wire

//--- testbench/ucrw_usb_host_model.sv
// Upstream side model: supplies the device state and times the K state it sees
`timescale 1ns/10ps
`default_nettype none

module ucrw_usb_host_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench control and bus observation
  input wire logic suspend_cmd,
  input wire logic wakeup_k_drive,
  // State and measurement
  output logic [2:0] device_state_field,
  output logic [31:0] k_len
);
  // Low bits churn every cycle so only the suspend bit can carry meaning
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_state_field <= 3'h0;
    end else begin
      device_state_field <= {suspend_cmd, 2'($urandom)};
    end
  end

  // Running total of K cycles; the bench takes differences
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      k_len <= 32'h0;
    end else if (wakeup_k_drive) begin
      k_len <= k_len + 32'h1;
    end
  end
endmodule : ucrw_usb_host_model
`default_nettype wire
